// File: bus_unit_status_pkg.sv
// Package with register map, field positions and carrier types of the bus unit status area
package bus_unit_status_pkg;

   // Bus geometry
   localparam int ADDR_W = 13;                  // Byte address width, covers index 0x76b
   localparam int IDX_W = 11;                   // Word index width
   localparam int NUM_UNITS = 16;               // Bus units 0 to 15
   localparam int NUM_PORTS = 8;                // Message ports 0 to 7

   // Register indices; byte address is four times the index
   localparam logic [IDX_W-1:0] RESTART_IDX = 11'h001;
   localparam logic [IDX_W-1:0] SVC_DISABLE_IDX = 11'h00f;
   localparam logic [IDX_W-1:0] INIT_FLAGS_IDX = 11'h12e;
   localparam logic [IDX_W-1:0] BUS_ERR_FLAG_IDX = 11'h191;
   localparam logic [IDX_W-1:0] SET_PAR_FLAG_IDX = 11'h192;
   localparam logic [IDX_W-1:0] BUS_ERR_UNIT_IDX = 11'h195;
   localparam logic [IDX_W-1:0] DUP_UNIT_IDX = 11'h19a;
   localparam logic [IDX_W-1:0] PARITY_UNIT_IDX = 11'h1a6;
   localparam logic [IDX_W-1:0] SETTING_UNIT_IDX = 11'h1ab;
   localparam logic [IDX_W-1:0] PORT_FLAGS_IDX = 11'h1f6;
   localparam logic [IDX_W-1:0] PORT_CODE_IDX = 11'h1f7;   // First of eight
   localparam logic [IDX_W-1:0] LINK_ACTIVE_IDX = 11'h1ff;  // Data link operation flags

   // Per-unit window: base + stride * unit, words 2 to 23 held
   localparam logic [IDX_W-1:0] WIN_BASE_IDX = 11'd1500;
   localparam logic [IDX_W-1:0] WIN_STRIDE = 11'd25;
   localparam logic [IDX_W-1:0] WIN_END_IDX = 11'd1900;    // One past the last window
   localparam logic [4:0] WIN_FIRST_WORD = 5'd2;
   localparam logic [4:0] WIN_LAST_WORD = 5'd23;
   localparam int WIN_HELD = 22;                           // Words +2 to +23
   localparam logic [4:0] MEMBER_LAST_WORD = 5'd5;         // Holds nodes 49 to 62
   localparam logic [15:0] MEMBER_LAST_MASK = 16'h3fff;    // No node above 62

   // Flag bit positions
   localparam int BUS_ERR_FLAG_BIT = 12;
   localparam int SETTING_FLAG_BIT = 3;
   localparam int UNIT_ERR_FLAG_BIT = 7;
   localparam int PORT_ERR_LSB = 8;

   // Reset values
   localparam logic [15:0] CTRL_RESET = 16'h0000;

   // Per-unit condition lines from the bus side
   typedef struct packed {
      logic [15:0] initializing;   // Level: unit is initializing
      logic [15:0] restart_done;   // Pulse: restart finished
      logic [15:0] xfer_err;       // Pulse: CPU-unit transfer failed
      logic [15:0] watchdog_timeout; // Pulse: unit watchdog expired
      logic [15:0] parity_err;     // Pulse: parity error on transfer
      logic [15:0] setting_err;    // Pulse: unit differs from configuration
      logic [15:0] link_active;    // Level: local data link running
   } unit_evt_t;

   // Duplicate unit number report
   typedef struct packed {
      logic valid;
      logic [3:0] unit_a;
      logic [3:0] unit_b;
   } dup_evt_t;

   // Message port status
   typedef struct packed {
      logic [7:0] free;            // Level: port may accept an instruction
      logic done;                  // Pulse: a transfer finished
      logic [2:0] port;
      logic err;
      logic [15:0] code;
   } port_evt_t;

   // Network window word update
   typedef struct packed {
      logic valid;
      logic [3:0] unit;
      logic [4:0] word;            // Window offset 2 to 23
      logic [15:0] data;
   } net_wr_t;

endpackage : bus_unit_status_pkg

// File: bus_unit_status_area.sv
// Status and control word area for sixteen bus units, reached over Avalon-MM
//
// The Avalon-MM register port is this design's own decision.
`timescale 1ns/1ns
`default_nettype none

// Summary of operation
// R1: Restart bit resets unit, self-clears when done
// R2: Restart bits driven from support tool only
// R3: Service-disable bit stops servicing that unit
// R4: Initializing flag follows unit initialization
// R5: Bus error flag on transfer fail, watchdog
// R6: Bus error sets offending unit's bit
// R7: Configuration mismatch sets setting flag, unit bit
// R8: Parity error sets unit flag, unit bit
// R9: Duplicate number sets both unit bits
// R10: Port enabled bits show free ports
// R11: Port error bits set on failed transfer
// R12: Completion code stored per port
// R13: Unit window: 25 words from 1500
// R14: Words 2-5 hold node membership bits
// R15: Top two bits of word 5 zero
// R16: Words 6-7 hold local, polling addresses
// R17: Words 8-23 hold node status nibbles
// R18: Link operation flag: 0 stopped, 1 active
// R19: Unit error bits sticky until restart or clear; port error bits until clear or a good transfer
module bus_unit_status_area (
   // Clock, reset, enable
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic ce,
   // Avalon-MM slave
   input wire logic [bus_unit_status_pkg::ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // Bus unit conditions
   input wire bus_unit_status_pkg::unit_evt_t unit_evt,
   input wire bus_unit_status_pkg::dup_evt_t dup_evt,
   input wire bus_unit_status_pkg::port_evt_t port_evt,
   input wire bus_unit_status_pkg::net_wr_t net_wr,
   // Unit control
   output logic [15:0] unit_restart_req,
   output logic [15:0] unit_service_hold
);
   import bus_unit_status_pkg::*;

   // Whole state of the block
   typedef struct packed {
      logic [15:0] restart;          // Restart requests
      logic [15:0] svc_disable;      // Service hold per unit
      logic [15:0] init;             // Initializing flags
      logic [15:0] bus_err_bits;     // Bus error per unit
      logic [15:0] dup_bits;         // Duplicate number per unit
      logic [15:0] parity_bits;      // Parity error per unit
      logic [15:0] setting_bits;     // Setting error per unit
      logic bus_err_flag;
      logic setting_flag;
      logic unit_err_flag;
      logic [7:0] port_en;           // Port free flags
      logic [7:0] port_err;          // Port error flags
      logic [7:0][15:0] port_code;   // Completion codes
      logic [15:0] link_active;      // Data link operation flags
      logic [15:0][WIN_HELD-1:0][15:0] net;  // Window words +2 to +23
      logic wait_n;                  // Low in the cycle a request completes
      logic [31:0] rdata;
   } state_t;

   state_t s_reg;       // Registered state
   state_t s_next;      // Next state

   logic [IDX_W-1:0] idx;       // Word index of the request
   logic req;                   // A request is present
   logic accept;                // Request completes this edge
   logic [15:0] wmask;          // Bits written by this access
   logic [15:0] wdata16;        // Low half of the write data
   logic [15:0] clr_mask;       // Write-one-to-clear bits
   logic [15:0] bus_set;        // Bus error sets this cycle
   logic [15:0] dup_set;        // Duplicate sets this cycle
   logic [15:0] restart_clear;  // Units whose restart finished
   logic [15:0] svc_on;         // Units currently serviced

   // Byte lanes 0 and 1 carry the 16-bit registers
   function automatic logic [15:0] lane_mask(input logic [3:0] be);
      lane_mask = {{8{be[1]}}, {8{be[0]}}};
   endfunction : lane_mask

   // Maps an index onto a unit window; hit when inside 1500 to 1899
   function automatic logic win_decode(input logic [IDX_W-1:0] i,
                                       output logic [3:0] unit,
                                       output logic [4:0] word);
      logic [IDX_W-1:0] off;
      logic [IDX_W-1:0] u;
      logic [IDX_W-1:0] w;
      off = i - WIN_BASE_IDX;
      u = off / WIN_STRIDE;
      w = off % WIN_STRIDE;
      unit = u[3:0];
      word = w[4:0];
      win_decode = (i >= WIN_BASE_IDX) && (i < WIN_END_IDX);  // R13
   endfunction : win_decode

   // Read value of one window word; unheld words read zero
   function automatic logic [15:0] win_read(input state_t st,
                                            input logic [3:0] unit,
                                            input logic [4:0] word);
      logic [4:0] rel;
      win_read = 16'h0000;
      rel = word - WIN_FIRST_WORD;
      if (word >= WIN_FIRST_WORD && word <= WIN_LAST_WORD) begin
         win_read = st.net[unit][rel];  // R14 R16 R17
         if (word == MEMBER_LAST_WORD) begin
            win_read = st.net[unit][rel] & MEMBER_LAST_MASK;  // R15
         end
      end
   endfunction : win_read

   // Register read mux; unmapped indices read zero
   function automatic logic [15:0] reg_read(input state_t st, input logic [IDX_W-1:0] i);
      logic [3:0] unit;
      logic [4:0] word;
      logic [IDX_W-1:0] pidx;
      reg_read = 16'h0000;
      pidx = i - PORT_CODE_IDX;
      if (win_decode(i, unit, word)) begin
         reg_read = win_read(st, unit, word);
      end else if (i >= PORT_CODE_IDX && i < PORT_CODE_IDX + IDX_W'(NUM_PORTS)) begin
         reg_read = st.port_code[pidx[2:0]];  // R12
      end else begin
         case (i)
            RESTART_IDX: reg_read = st.restart;
            SVC_DISABLE_IDX: reg_read = st.svc_disable;
            INIT_FLAGS_IDX: reg_read = st.init;  // R4
            BUS_ERR_FLAG_IDX: reg_read[BUS_ERR_FLAG_BIT] = st.bus_err_flag;  // R5
            SET_PAR_FLAG_IDX: begin
               reg_read[SETTING_FLAG_BIT] = st.setting_flag;  // R7
               reg_read[UNIT_ERR_FLAG_BIT] = st.unit_err_flag;  // R8
            end
            BUS_ERR_UNIT_IDX: reg_read = st.bus_err_bits;  // R6
            DUP_UNIT_IDX: reg_read = st.dup_bits;  // R9
            PARITY_UNIT_IDX: reg_read = st.parity_bits;
            SETTING_UNIT_IDX: reg_read = st.setting_bits;
            PORT_FLAGS_IDX: reg_read = {st.port_err, st.port_en};  // R10 R11
            LINK_ACTIVE_IDX: reg_read = st.link_active;  // R18
            default: reg_read = 16'h0000;
         endcase
      end
   endfunction : reg_read

   // Request decode; the slave always inserts one wait state
   always_comb begin
      idx = avs_address[ADDR_W-1:2];
      req = avs_read | avs_write;
      accept = req & ~s_reg.wait_n;
      wmask = lane_mask(avs_byteenable);
      wdata16 = avs_writedata[15:0];
      clr_mask = (accept && avs_write) ? (wdata16 & wmask) : 16'h0000;
   end

   // Event terms shared by several flag groups
   always_comb begin
      svc_on = ~s_reg.svc_disable;
      restart_clear = unit_evt.restart_done;
      bus_set = unit_evt.xfer_err | unit_evt.watchdog_timeout;  // R5
      dup_set = 16'h0000;
      if (dup_evt.valid) begin
         dup_set[dup_evt.unit_a] = 1'b1;  // R9
         dup_set[dup_evt.unit_b] = 1'b1;  // R9
      end
   end

   // Next-state logic
   always_comb begin
      s_next = s_reg;

      // Bus handshake: first cycle loads read data, second releases the master
      if (req && s_reg.wait_n) begin
         s_next.wait_n = 1'b0;
         // Only a read loads new data; a write leaves the last read data standing
         if (avs_read) begin
            s_next.rdata = {16'h0000, reg_read(s_reg, idx)};
         end
      end else begin
         s_next.wait_n = 1'b1;
      end

      // Restart: hardware clears on completion, a software write in the same cycle wins
      s_next.restart = s_reg.restart & ~restart_clear;  // R1
      if (accept && avs_write && idx == RESTART_IDX) begin
         s_next.restart = (s_next.restart & ~wmask) | (wdata16 & wmask);  // R1
      end

      // Service hold is plain software state
      if (accept && avs_write && idx == SVC_DISABLE_IDX) begin
         s_next.svc_disable = (s_reg.svc_disable & ~wmask) | (wdata16 & wmask);  // R3
      end

      // Initializing flags track the units one cycle late
      s_next.init = unit_evt.initializing;  // R4
      s_next.link_active = unit_evt.link_active;  // R18

      // Sticky error bits: unit bits cleared by restart or write-one, port bits by write-one, a new event wins
      s_next.bus_err_bits = s_reg.bus_err_bits & ~restart_clear;  // R19
      s_next.dup_bits = s_reg.dup_bits & ~restart_clear;
      s_next.parity_bits = s_reg.parity_bits & ~restart_clear;
      s_next.setting_bits = s_reg.setting_bits & ~restart_clear;
      if (accept && avs_write) begin
         case (idx)
            BUS_ERR_UNIT_IDX: s_next.bus_err_bits = s_next.bus_err_bits & ~clr_mask;
            DUP_UNIT_IDX: s_next.dup_bits = s_next.dup_bits & ~clr_mask;
            PARITY_UNIT_IDX: s_next.parity_bits = s_next.parity_bits & ~clr_mask;
            SETTING_UNIT_IDX: s_next.setting_bits = s_next.setting_bits & ~clr_mask;
            PORT_FLAGS_IDX: s_next.port_err = s_reg.port_err & ~clr_mask[15:8];
            default: s_next.port_err = s_reg.port_err;
         endcase
      end
      s_next.bus_err_bits = s_next.bus_err_bits | (bus_set & svc_on);  // R6
      s_next.dup_bits = s_next.dup_bits | dup_set;  // R9
      s_next.parity_bits = s_next.parity_bits | (unit_evt.parity_err & svc_on);  // R8
      s_next.setting_bits = s_next.setting_bits | unit_evt.setting_err;  // R7

      // Summary flags stand while any unit bit stands
      s_next.bus_err_flag = |s_next.bus_err_bits;  // R5
      s_next.setting_flag = |s_next.setting_bits;  // R7
      s_next.unit_err_flag = |s_next.parity_bits;  // R8

      // Message ports
      s_next.port_en = port_evt.free;  // R10
      if (port_evt.done) begin
         s_next.port_code[port_evt.port] = port_evt.code;  // R12
         if (port_evt.err) begin
            s_next.port_err[port_evt.port] = 1'b1;  // R11
         end else begin
            s_next.port_err[port_evt.port] = 1'b0;
         end
      end

      // Window words refreshed by serviced units only
      if (net_wr.valid && svc_on[net_wr.unit] &&
          net_wr.word >= WIN_FIRST_WORD && net_wr.word <= WIN_LAST_WORD) begin
         s_next.net[net_wr.unit][5'(net_wr.word - WIN_FIRST_WORD)] = net_wr.data;  // R14 R17
      end
   end

   // State register; clock enable low freezes everything
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         s_reg <= '0;
         s_reg.restart <= CTRL_RESET;
         s_reg.svc_disable <= CTRL_RESET;
         s_reg.wait_n <= 1'b1;
      end else if (ce) begin
         s_reg <= s_next;
      end
   end

   // Outputs straight from the state register
   always_comb begin
      avs_readdata = s_reg.rdata;
      avs_waitrequest = s_reg.wait_n;
      unit_restart_req = s_reg.restart;  // R1
      unit_service_hold = s_reg.svc_disable;  // R3
   end

endmodule : bus_unit_status_area
`default_nettype wire

// File: bus_unit_status_chk.sv
// Port assertions for the bus unit status area
`timescale 1ns/1ns
`default_nettype none
module bus_unit_status_chk (
   // Clock, reset, enable
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic ce,
   // Avalon-MM slave
   input wire logic [bus_unit_status_pkg::ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   // Unit side
   input wire bus_unit_status_pkg::unit_evt_t unit_evt,
   input wire logic [15:0] unit_restart_req,
   input wire logic [15:0] unit_service_hold
);
   import bus_unit_status_pkg::*;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   logic wr_rst; // Write completing on the restart word
   logic wr_svc; // Write completing on the service-disable word
   assign wr_rst = ce && avs_write && !avs_waitrequest && avs_address[12:2] == RESTART_IDX;
   assign wr_svc = ce && avs_write && !avs_waitrequest && avs_address[12:2] == SVC_DISABLE_IDX;
   // A fresh request in its single wait cycle, then the answer cycle with waitrequest low
   sequence s_req;
      ce && (avs_read || avs_write) && avs_waitrequest;
   endsequence
   sequence s_ans;
      !avs_waitrequest ##1 avs_waitrequest;
   endsequence
   a_one_wait_state: assert property (s_req |=> s_ans)
      else $error("waitrequest not low for exactly one cycle");
   a_no_idle_answer: assert property (ce && !avs_read && !avs_write && avs_waitrequest |=> avs_waitrequest)
      else $error("answer without a request");
   a_read_upper_zero: assert property (!avs_waitrequest |-> avs_readdata[31:16] == 16'h0000)
      else $error("upper read data not zero");
   a_read_data_stands: assert property (ce && !avs_read |=> $stable(avs_readdata))
      else $error("read data changed without a read");
   a_restart_write: assert property (wr_rst |=> unit_restart_req == $past(avs_writedata[15:0]))
      else $error("restart request does not follow write");
   a_restart_self_clear: assert property (ce && !wr_rst |=>
      unit_restart_req == ($past(unit_restart_req) & ~$past(unit_evt.restart_done)))
      else $error("restart bit not cleared by completion");
   a_hold_write: assert property (wr_svc |=> unit_service_hold == $past(avs_writedata[15:0]))
      else $error("service hold does not follow write");
   a_hold_steady: assert property (ce && !wr_svc |=> $stable(unit_service_hold))
      else $error("service hold changed without a write");
   a_freeze_no_ce: assert property (!ce |=> $stable(unit_restart_req) && $stable(avs_waitrequest))
      else $error("state moved with clock enable low");
endmodule : bus_unit_status_chk
bind bus_unit_status_area bus_unit_status_chk bus_unit_status_chk_inst (
   .ref_clk(ref_clk), .rst_n(rst_n), .ce(ce), .avs_address(avs_address),
   .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
   .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .unit_evt(unit_evt),
   .unit_restart_req(unit_restart_req), .unit_service_hold(unit_service_hold));
`default_nettype wire

// File: bus_unit_model.sv
// Behavioural model of the sixteen bus units
`timescale 1ns/1ns
`default_nettype none
module bus_unit_model (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // Requests from the block and faults from the bench
   input wire logic [15:0] restart_req,
   input wire bus_unit_status_pkg::unit_evt_t inj,
   // Condition lines toward the block
   output var bus_unit_status_pkg::unit_evt_t unit_evt
);
   import bus_unit_status_pkg::*;
   logic [15:0][2:0] step_reg; // Restart progress per unit, 0 idle, 6 waits for release
   // A unit initializes four cycles, then reports done once
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         step_reg <= '0;
      end else begin
         for (int n = 0; n < 16; n++) begin
            if (step_reg[n] == 3'h0) begin
               step_reg[n] <= restart_req[n] ? 3'h1 : 3'h0;
            end else if (step_reg[n] == 3'h6) begin
               step_reg[n] <= restart_req[n] ? 3'h6 : 3'h0; // No second restart on a held bit
            end else begin
               step_reg[n] <= step_reg[n] + 3'h1;
            end
         end
      end
   end
   // Faults pass through; restart lines come from the progress counters
   always_comb begin
      unit_evt = inj;
      for (int n = 0; n < 16; n++) begin
         unit_evt.initializing[n] = step_reg[n] inside {[3'h1:3'h4]};
         unit_evt.restart_done[n] = step_reg[n] == 3'h5;
      end
   end
endmodule : bus_unit_model
`default_nettype wire

// File: test_bus_unit_status_area.sv
// Self-checking testbench for the bus unit status area
`timescale 1ns/1ns
`default_nettype none
module test_bus_unit_status_area;
   import bus_unit_status_pkg::*;
   // Clock, reset and bus
   logic ref_clk = 1'b0;
   logic rst_n = 1'b0;
   logic ce = 1'b1;
   logic [ADDR_W-1:0] avs_address = '0;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = '0;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   // Unit side
   unit_evt_t inj = '0; // Faults handed to the unit model
   unit_evt_t unit_evt;
   dup_evt_t dup_evt = '0;
   port_evt_t port_evt = '0;
   net_wr_t net_wr = '0;
   logic [15:0] unit_restart_req;
   logic [15:0] unit_service_hold;
   // Bookkeeping
   int fails = 0;
   int tests_run = 0;
   int cyc = 0;
   logic [15:0] rd;
   bus_unit_status_area bus_unit_status_area_inst (
      .ref_clk(ref_clk), .rst_n(rst_n), .ce(ce), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(4'hf), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .unit_evt(unit_evt), .dup_evt(dup_evt), .port_evt(port_evt), .net_wr(net_wr),
      .unit_restart_req(unit_restart_req), .unit_service_hold(unit_service_hold));
   bus_unit_model bus_unit_model_inst (
      .ref_clk(ref_clk), .rst_n(rst_n), .restart_req(unit_restart_req), .inj(inj),
      .unit_evt(unit_evt));
   // Free-running 125 MHz clock
   initial begin
      forever #4 ref_clk = ~ref_clk;
   end
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp) begin
         fails++;
         $display("ERROR %0t: got %h, expected %h", $time, got, exp);
      end
   endtask : chk
   // One Avalon access; holds the request until waitrequest is seen low
   task automatic bus(input logic wr, input logic [10:0] idx, input logic [15:0] wd);
      int n;
      n = 0;
      @(posedge ref_clk);
      avs_address <= {idx, 2'b00};
      avs_writedata <= {16'h0000, wd};
      avs_write <= wr;
      avs_read <= !wr;
      @(posedge ref_clk);
      while (avs_waitrequest !== 1'b0 && n < 40) begin
         @(posedge ref_clk);
         n++;
      end
      rd = avs_readdata[15:0];
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      chk(16'(n < 40), 16'h0001);
   endtask : bus
   task automatic rc(input logic [10:0] idx, input logic [15:0] exp);
      bus(1'b0, idx, 16'h0000);
      chk(rd, exp);
   endtask : rc
   // One-cycle fault pulses: transfer, watchdog, parity, setting
   task automatic fault(input logic [15:0] xf, input logic [15:0] wd, input logic [15:0] pa,
                        input logic [15:0] st);
      @(posedge ref_clk);
      inj <= '{16'h0, 16'h0, xf, wd, pa, st, 16'h0};
      @(posedge ref_clk);
      inj <= '0;
   endtask : fault
   task automatic nw(input logic [3:0] u, input logic [4:0] w, input logic [15:0] d);
      @(posedge ref_clk);
      net_wr <= '{1'b1, u, w, d};
      @(posedge ref_clk);
      net_wr <= '0;
   endtask : nw
   function automatic logic [10:0] widx(input int u, input int w);
      return WIN_BASE_IDX + WIN_STRIDE * 11'(u) + 11'(w);
   endfunction : widx
   task automatic test_done();
      $display("Comparisons %0d, mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : test_done
   // Reset values, unmapped and read-only writes, clock enable pause
   task automatic t_basic();
      rc(RESTART_IDX, 16'h0000);
      rc(SVC_DISABLE_IDX, 16'h0000);
      bus(1'b1, 11'h100, 16'hffff);
      rc(11'h100, 16'h0000);
      bus(1'b1, INIT_FLAGS_IDX, 16'hffff);
      rc(INIT_FLAGS_IDX, 16'h0000);
      @(posedge ref_clk);
      ce <= 1'b0;
      @(posedge ref_clk);
      ce <= 1'b1;
      $display("basic done");
   endtask : t_basic
   // Restart unit 5 with a parity fault pending; restart clears it
   task automatic t_restart();
      fault(16'h0, 16'h0, 16'h0020, 16'h0);
      rc(PARITY_UNIT_IDX, 16'h0020);
      bus(1'b1, RESTART_IDX, 16'h0020);
      @(negedge ref_clk);
      chk(unit_restart_req, 16'h0020);
      @(posedge ref_clk);
      rc(INIT_FLAGS_IDX, 16'h0020);
      for (int n = 0; n < 20 && unit_restart_req !== 16'h0; n++) @(negedge ref_clk);
      chk(unit_restart_req, 16'h0000);
      rc(RESTART_IDX, 16'h0000);
      rc(INIT_FLAGS_IDX, 16'h0000);
      rc(PARITY_UNIT_IDX, 16'h0000);
      $display("restart done");
   endtask : t_restart
   // All fault kinds at once, sticky, then bus error bits cleared by writing ones
   task automatic t_faults();
      fault(16'h0008, 16'h0200, 16'h0010, 16'h0004);
      repeat (5) @(posedge ref_clk);
      rc(BUS_ERR_UNIT_IDX, 16'h0208);
      rc(BUS_ERR_FLAG_IDX, 16'h1000);
      rc(SET_PAR_FLAG_IDX, 16'h0088);
      rc(PARITY_UNIT_IDX, 16'h0010);
      rc(SETTING_UNIT_IDX, 16'h0004);
      bus(1'b1, BUS_ERR_UNIT_IDX, 16'h0008);
      rc(BUS_ERR_UNIT_IDX, 16'h0200);
      bus(1'b1, BUS_ERR_UNIT_IDX, 16'h0200);
      rc(BUS_ERR_FLAG_IDX, 16'h0000);
      $display("faults done");
   endtask : t_faults
   // Held unit ignores transfer faults until service resumes
   task automatic t_hold();
      bus(1'b1, SVC_DISABLE_IDX, 16'h0008);
      @(negedge ref_clk);
      chk(unit_service_hold, 16'h0008);
      fault(16'h0008, 16'h0, 16'h0, 16'h0);
      rc(BUS_ERR_UNIT_IDX, 16'h0000);
      bus(1'b1, SVC_DISABLE_IDX, 16'h0000);
      fault(16'h0008, 16'h0, 16'h0, 16'h0);
      rc(BUS_ERR_UNIT_IDX, 16'h0008);
      @(posedge ref_clk);
      dup_evt <= '{1'b1, 4'd1, 4'd15};
      @(posedge ref_clk);
      dup_evt <= '0;
      rc(DUP_UNIT_IDX, 16'h8002);
      $display("hold done");
   endtask : t_hold
   // Every port finishes; odd ports fail
   task automatic t_port();
      for (int p = 0; p < 8; p++) begin
         @(posedge ref_clk);
         port_evt <= '{8'ha5, 1'b1, 3'(p), p[0], 16'hc000 + 16'(p)};
      end
      @(posedge ref_clk);
      port_evt <= '{8'ha5, 1'b0, 3'h0, 1'b0, 16'h0000};
      for (int p = 0; p < 8; p++) rc(PORT_CODE_IDX + 11'(p), 16'hc000 + 16'(p));
      rc(PORT_FLAGS_IDX, 16'haaa5);
      $display("port done");
   endtask : t_port
   // Window placement, membership mask, addresses, link status
   task automatic t_window();
      nw(4'd15, 5'd5, 16'hffff);
      nw(4'd0, 5'd2, 16'h1234);
      nw(4'd3, 5'd6, 16'h0102);
      nw(4'd7, 5'd23, 16'ha5c3);
      nw(4'd3, 5'd1, 16'hffff);
      rc(widx(15, 5), 16'h3fff);
      rc(widx(0, 2), 16'h1234);
      rc(widx(3, 6), 16'h0102);
      rc(widx(7, 23), 16'ha5c3);
      rc(widx(3, 1), 16'h0000);
      @(posedge ref_clk);
      inj <= '{16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h8001};
      rc(LINK_ACTIVE_IDX, 16'h8001);
      @(posedge ref_clk);
      inj <= '0;
      $display("window done");
   endtask : t_window
   // Hang guard
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 5000) begin
         fails++;
         test_done();
      end
   end
   // Main sequence
   initial begin
      repeat (12) @(posedge ref_clk);
      rst_n <= 1'b1;
      t_basic();
      t_restart();
      t_faults();
      t_hold();
      t_port();
      t_window();
      test_done();
   end
endmodule : test_bus_unit_status_area
`default_nettype wire
